// ### hdl/smx_channel_mapper.v
// Purpose: spreads high-rate channels over base-rate link slots
// Assumes: link word clock is the cleaned recovered clock
// Notes: load the transmit frame between frames; writes during one race
`timescale 1ns/1ps
`default_nettype none
`include "smx_map.vh"
module smx_channel_mapper (
  input  wire        mclk,
  input  wire        reset,
  input  wire        linkWordClk,
  input  wire [1:0]  speedMode,
  input  wire [1:0]  portSel,
  input  wire        nativeReq,
  input  wire        txWrValid,
  input  wire [5:0]  txWrChan,
  input  wire [1:0]  txWrPhase,
  input  wire [23:0] txWrData,
  input  wire        rxInValid,
  input  wire [5:0]  rxInSlot,
  input  wire [23:0] rxInData,
  output reg         txWrReject_q,
  output reg         frameStart_q,
  output reg         linkOutValid_q,
  output reg  [5:0]  linkOutSlot_q,
  output reg  [23:0] linkOutData_q,
  output reg  [4:0]  aesLine_q,
  output reg         aesSubB_q,
  output reg         linkBaseRate_q,
  output reg         frameNative_q,
  output reg  [2:0]  factor_q,
  output reg  [6:0]  usableChans_q,
  output reg         rateError_q,
  output reg         rxOutValid_q,
  output reg  [5:0]  rxOutChan_q,
  output reg  [1:0]  rxOutPhase_q,
  output reg  [23:0] rxOutData_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  // Periods are worked out in 32 bits, then cut to the counter width
  localparam integer M64_MIN_I = `SMX_M64_MIN_PERIOD;
  localparam integer M56_MIN_I = `SMX_M56_MIN_PERIOD;
  localparam integer M56_MAX_I = `SMX_M56_MAX_PERIOD;
  localparam [11:0]  M64_MIN   = M64_MIN_I[11:0];
  localparam [11:0]  M56_MIN   = M56_MIN_I[11:0];
  localparam [11:0]  M56_MAX   = M56_MAX_I[11:0];

  wire        wordClkLvl;
  reg         wordClkPrev_q;
  wire        frameEdge;
  reg         state_q;
  reg         state_d;
  reg  [6:0]  slotCnt_q;
  reg  [6:0]  slotCnt_d;
  reg  [6:0]  frameLen_q;
  reg  [1:0]  shift_q;
  reg  [1:0]  portAct_q;
  reg  [11:0] period_q;
  reg         periodValid_q;
  reg         rdPend_q;
  reg  [5:0]  rdSlot_q;
  wire [23:0] ramData;

  reg         nativeAct;
  reg  [1:0]  shiftNew;
  reg  [6:0]  lenNew;
  wire [5:0]  txAddr;
  wire        txOk;
  wire [1:0]  phaseMask;

  // Word clock is foreign: sample it, act on its rising edge only
  smx_sync3 u_wordSync (
    .mclk   (mclk),
    .reset  (reset),
    .din    (linkWordClk),
    .dout_q (wordClkLvl)
  );

  assign frameEdge = wordClkLvl & ~wordClkPrev_q; // RULE15

  // Mode decode taken from the live controls, latched per frame
  always @* begin
    nativeAct = nativeReq && (speedMode == `SMX_SPEED_DOUBLE)
                && (portSel == `SMX_PORT_MADI64); // RULE4 RULE8
    case (speedMode)
      `SMX_SPEED_DOUBLE: shiftNew = nativeAct ? 2'h0 : 2'h1; // RULE1 RULE5
      `SMX_SPEED_QUAD:   shiftNew = 2'h2; // RULE7 RULE9
      default:           shiftNew = 2'h0;
    endcase
    case (portSel)
      `SMX_PORT_MADI56:  lenNew = `SMX_SLOTS_56; // RULE13
      `SMX_PORT_OPTICAL: lenNew = `SMX_SLOTS_OPT;
      default:           lenNew = nativeAct ? `SMX_SLOTS_NATIVE : `SMX_SLOTS_64;
    endcase
  end

  // Mode takes effect at a frame boundary so both paths switch together
  always @(posedge mclk) begin
    if (reset) begin
      wordClkPrev_q  <= 1'b0;
      shift_q        <= 2'h0;
      frameLen_q     <= `SMX_SLOTS_64;
      portAct_q      <= `SMX_PORT_MADI64;
      factor_q       <= 3'h1;
      usableChans_q  <= `SMX_SLOTS_64;
      frameNative_q  <= 1'b0;
      linkBaseRate_q <= 1'b1;
    end else begin
      wordClkPrev_q <= wordClkLvl;
      if (frameEdge && (state_q == ST_IDLE)) begin
        shift_q        <= shiftNew; // RULE17
        frameLen_q     <= lenNew;
        portAct_q      <= portSel;
        factor_q       <= 3'h1 << shiftNew;
        usableChans_q  <= lenNew >> shiftNew; // RULE2 RULE7
        frameNative_q  <= nativeAct; // RULE4
        linkBaseRate_q <= ~nativeAct; // RULE3 RULE6
      end
    end
  end

  // Word clock period check against the framing's rate window
  always @(posedge mclk) begin
    if (reset) begin
      period_q      <= 12'h000;
      periodValid_q <= 1'b0;
      rateError_q   <= 1'b0;
    end else if (frameEdge) begin
      period_q      <= 12'h001;
      periodValid_q <= 1'b1;
      if (periodValid_q && !frameNative_q) begin
        case (portAct_q)
          `SMX_PORT_MADI64: rateError_q <= (period_q < M64_MIN); // RULE12 RULE14
          `SMX_PORT_MADI56: rateError_q <= (period_q < M56_MIN)
                                           || (period_q > M56_MAX); // RULE13 RULE14
          default:          rateError_q <= 1'b0;
        endcase
      end
    end else if (period_q != 12'hfff) begin
      period_q <= period_q + 12'h001;
    end else begin
      // A stalled word clock counts as a rate fault
      rateError_q   <= 1'b1;
      periodValid_q <= 1'b0;
    end
  end

  // Transmit side: channel and phase to link slot
  assign phaseMask = (shift_q == 2'h2) ? 2'h3 : ((shift_q == 2'h1) ? 2'h1 : 2'h0);
  assign txAddr    = (txWrChan << shift_q) | {4'h0, txWrPhase & phaseMask}; // RULE16
  assign txOk      = ({1'b0, txWrChan} < usableChans_q)
                     && ((txWrPhase & ~phaseMask) == 2'h0); // RULE2 RULE7

  always @(posedge mclk) begin
    if (reset) begin
      txWrReject_q <= 1'b0;
    end else begin
      txWrReject_q <= txWrValid & ~txOk;
    end
  end

  smx_slot_ram u_slotRam (
    .mclk     (mclk),
    .wrEn     (txWrValid & txOk),
    .wrAddr   (txAddr),
    .wrData   (txWrData),
    .rdAddr   (slotCnt_q[5:0]),
    .rdData_q (ramData)
  );

  // Frame sender: one slot per cycle from the word clock edge
  always @* begin
    state_d   = state_q;
    slotCnt_d = slotCnt_q;
    case (state_q)
      ST_IDLE: begin
        slotCnt_d = 7'h00;
        if (frameEdge) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (slotCnt_q == frameLen_q - 7'h01) begin
          state_d   = ST_IDLE;
          slotCnt_d = 7'h00;
        end else begin
          slotCnt_d = slotCnt_q + 7'h01; // RULE16
        end
      end
      default: begin
        state_d   = ST_IDLE;
        slotCnt_d = 7'h00;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      slotCnt_q <= 7'h00;
      rdPend_q  <= 1'b0;
      rdSlot_q  <= 6'h00;
    end else begin
      state_q   <= state_d;
      slotCnt_q <= slotCnt_d;
      rdPend_q  <= (state_q == ST_SEND);
      rdSlot_q  <= slotCnt_q[5:0];
    end
  end

  // Extra register stage keeps every output straight from a flop
  always @(posedge mclk) begin
    if (reset) begin
      frameStart_q   <= 1'b0;
      linkOutValid_q <= 1'b0;
      linkOutSlot_q  <= 6'h00;
      linkOutData_q  <= 24'h000000;
      aesLine_q      <= 5'h00;
      aesSubB_q      <= 1'b0;
    end else begin
      frameStart_q   <= frameEdge && (state_q == ST_IDLE); // RULE3
      linkOutValid_q <= rdPend_q;
      if (rdPend_q) begin
        linkOutSlot_q <= rdSlot_q;
        linkOutData_q <= ramData;
        aesLine_q     <= rdSlot_q[5:1]; // RULE10 RULE11
        aesSubB_q     <= rdSlot_q[0]; // RULE10 RULE11
      end
    end
  end

  // Receive side: link slot back to channel and phase, same factor
  always @(posedge mclk) begin
    if (reset) begin
      rxOutValid_q <= 1'b0;
      rxOutChan_q  <= 6'h00;
      rxOutPhase_q <= 2'h0;
      rxOutData_q  <= 24'h000000;
    end else begin
      rxOutValid_q <= rxInValid && ({1'b0, rxInSlot} < frameLen_q);
      if (rxInValid) begin
        rxOutChan_q  <= rxInSlot >> shift_q; // RULE17 RULE1 RULE7
        rxOutPhase_q <= rxInSlot[1:0] & phaseMask; // RULE16
        rxOutData_q  <= rxInData;
      end
    end
  end
endmodule
`default_nettype wire

// ### shared/smx_map.vh
// Purpose: constants for the sample interleaving channel mapper
// Assumes: mclk at 50 MHz, link word clock sampled through a three-stage synchroniser
// Notes: timing counts derive from the rates below
// How it works
// (RULE1) Double rate: one channel into two slots
// (RULE2) Double rate on 64 slots: 32 channels
// (RULE3) Link frame stays at base rate
// (RULE4) 96k: interleaved base framing or native frame
// (RULE5) Optical port interleaves two-way in double rate
// (RULE6) Optical carrier stays at base rate
// (RULE7) Quad rate: four slots, 16 channels usable
// (RULE8) Quad rate only interleaved, never native
// (RULE9) Optical port interleaves four-way in quad rate
// (RULE10) Double wire: one channel per line
// (RULE11) Quad wire: half a channel per line
// (RULE12) 64-slot framing: base rate below 48k plus 1%
// (RULE13) 56-slot framing tolerates 12.5% deviation
// (RULE14) Payload under 100 Mbit/s, 125 after coding
// (RULE15) Recovered link clock times all outputs; here mclk clocks every output, the word clock only starts frames
// (RULE16) Earliest sample in lowest slot, ascending
// (RULE17) Factor from speed mode, same both paths
`ifndef SMX_MAP_VH
`define SMX_MAP_VH

`define SMX_CLK_HZ          50000000
`define SMX_DATA_W          24
`define SMX_SLOT_W          6
`define SMX_SLOTS_64        7'h40
`define SMX_SLOTS_56        7'h38
`define SMX_SLOTS_OPT       7'h08
`define SMX_SLOTS_NATIVE    7'h20

`define SMX_SPEED_SINGLE    2'h0
`define SMX_SPEED_DOUBLE    2'h1
`define SMX_SPEED_QUAD      2'h2

`define SMX_PORT_MADI64     2'h0
`define SMX_PORT_MADI56     2'h1
`define SMX_PORT_OPTICAL    2'h2

`define SMX_BASE_HZ         48000
`define SMX_M64_MAX_HZ      48480
`define SMX_M56_MAX_HZ      54000
`define SMX_M56_MIN_HZ      38587
`define SMX_PAYLOAD_MBPS    100
`define SMX_LINE_MBPS       125

`define SMX_M64_MIN_PERIOD  ((`SMX_CLK_HZ + `SMX_M64_MAX_HZ - 1) / `SMX_M64_MAX_HZ)
`define SMX_M56_MIN_PERIOD  ((`SMX_CLK_HZ + `SMX_M56_MAX_HZ - 1) / `SMX_M56_MAX_HZ)
`define SMX_M56_MAX_PERIOD  (`SMX_CLK_HZ / `SMX_M56_MIN_HZ)

`endif

// ### hdl/smx_sync3.v
// Purpose: three-stage level synchroniser
// Assumes: input from a foreign clock or a pin
// Notes: level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module smx_sync3 (
  input  wire mclk,
  input  wire reset,
  input  wire din,
  output reg  dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge mclk) begin
    if (reset) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/smx_slot_ram.v
// Purpose: one frame of link slot samples
// Assumes: one write and one read port on mclk
// Notes: read data come out of a register, one cycle late
`timescale 1ns/1ps
`default_nettype none
module smx_slot_ram (
  input  wire        mclk,
  input  wire        wrEn,
  input  wire [5:0]  wrAddr,
  input  wire [23:0] wrData,
  input  wire [5:0]  rdAddr,
  output reg  [23:0] rdData_q
);
  reg [23:0] mem [0:63];

  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData_q <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ### verif/smx_mapper_props.sv
// Purpose: port checks for the channel mapper
// Assumes: sees only the mapper's ports
// Notes: one clock domain, reset disables all
`timescale 1ns/1ps
`default_nettype none
module smx_mapper_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        txWrValid,
  input wire logic [5:0]  txWrChan,
  input wire logic [5:0]  rxInSlot,
  input wire logic        txWrReject_q,
  input wire logic        frameStart_q,
  input wire logic        linkOutValid_q,
  input wire logic [5:0]  linkOutSlot_q,
  input wire logic [4:0]  aesLine_q,
  input wire logic        aesSubB_q,
  input wire logic        linkBaseRate_q,
  input wire logic        frameNative_q,
  input wire logic [2:0]  factor_q,
  input wire logic [6:0]  usableChans_q,
  input wire logic        rxOutValid_q,
  input wire logic [5:0]  rxOutChan_q,
  input wire logic [1:0]  rxOutPhase_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_usable_count: assert property (
    !frameNative_q |-> (usableChans_q * factor_q) inside {64, 56, 8}) else $error("usable count");
  chk_quad_interleaved: assert property (
    factor_q == 3'h4 |-> !frameNative_q) else $error("quad frame native");
  chk_base_carrier: assert property (
    linkBaseRate_q == !frameNative_q) else $error("base carrier");
  chk_slot_ascend: assert property (
    linkOutValid_q && $past(linkOutValid_q) |-> linkOutSlot_q == $past(linkOutSlot_q) + 6'h01)
    else $error("slot order");
  chk_aes_pairing: assert property (
    linkOutValid_q |-> aesLine_q == linkOutSlot_q[5:1] && aesSubB_q == linkOutSlot_q[0])
    else $error("aes pairing");
  chk_frame_lead: assert property (
    frameStart_q |-> ##2 (linkOutValid_q && linkOutSlot_q == 6'h00)) else $error("frame lead");
  chk_rx_split: assert property (
    rxOutValid_q |-> $past(rxInSlot) == rxOutChan_q * factor_q + rxOutPhase_q)
    else $error("rx split");
  chk_tx_reject: assert property (
    txWrValid && ({1'b0, txWrChan} >= usableChans_q) |=> txWrReject_q) else $error("tx reject");
  cover property (frameStart_q && factor_q == 3'h4);
  cover property (frameStart_q && frameNative_q);
  cover property (txWrReject_q);
endmodule
`default_nettype wire

// ### verif/smx_word_src.sv
// Purpose: far-end recovered word clock source
// Assumes: one rising edge per frame request
// Notes: idles low between frames
`timescale 1ns/1ps
`default_nettype none
module smx_word_src (
  input  wire logic frameReq,
  output var  logic linkWordClk
);
  initial linkWordClk = 1'b0;
  // Odd offset keeps phase unrelated to mclk
  always @(posedge frameReq) begin
    #37 linkWordClk = 1'b1;
    #80 linkWordClk = 1'b0;
  end
endmodule
`default_nettype wire

// ### verif/smx_tb.sv
// Purpose: self-checking bench for the channel mapper
// Assumes: one frame edge per scenario step
// Notes: table rows {speed,port,native,nativeExp,factor,usable}
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        frameReq = 1'b0;
  logic [1:0]  speedMode = 2'h0, portSel = 2'h0, txWrPhase = 2'h0;
  logic        nativeReq = 1'b0, txWrValid = 1'b0, rxInValid = 1'b0;
  logic [5:0]  txWrChan = 6'h00, rxInSlot = 6'h00;
  logic [23:0] txWrData = 24'h000000, rxInData = 24'h000000;
  logic        linkWordClk, txWrReject_q, frameStart_q, linkOutValid_q, aesSubB_q;
  logic        linkBaseRate_q, frameNative_q, rateError_q, rxOutValid_q;
  logic [5:0]  linkOutSlot_q, rxOutChan_q;
  logic [23:0] linkOutData_q, rxOutData_q, got;
  logic [4:0]  aesLine_q;
  logic [2:0]  factor_q;
  logic [6:0]  usableChans_q;
  logic [1:0]  rxOutPhase_q;
  logic [15:0] tab [8] = '{16'h00c0, 16'h4120, 16'h8210, 16'h511c,
                           16'h6104, 16'ha202, 16'h4ca0, 16'h8a10};
  int          errorCnt = 0, samplesChecked = 0, cycles = 0;
  smx_channel_mapper i_dut (.*);
  smx_word_src i_src (.frameReq(frameReq), .linkWordClk(linkWordClk));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errorCnt++;
      giveVerdict();
    end
  end
  task automatic giveVerdict();
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] seen);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Frame with mode from a table row, capture one slot
  task automatic runFrame(input logic [15:0] t, input logic [5:0] sl, output logic [23:0] cap);
    int n;
    cap = 24'h000000;
    @(posedge mclk);
    speedMode <= t[15:14];
    portSel <= t[13:12];
    nativeReq <= t[11];
    frameReq <= 1'b1;
    @(posedge mclk);
    frameReq <= 1'b0;
    n = 0;
    while (frameStart_q !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp("frameStart", 24'h000001, 24'(frameStart_q));
    cmp("factor", 24'(t[9:7]), 24'(factor_q));
    cmp("usable", 24'(t[6:0]), 24'(usableChans_q));
    cmp("native", 24'(t[10]), 24'(frameNative_q));
    cmp("baseRate", 24'(!t[10]), 24'(linkBaseRate_q));
    // Long enough for a full 64-slot send before the next edge
    for (n = 0; n < 80; n++) begin
      @(posedge mclk);
      #1;
      if (linkOutValid_q === 1'b1 && linkOutSlot_q === sl) cap = linkOutData_q;
    end
  endtask
  task automatic writeSample(input logic [5:0] ch, input logic [1:0] ph,
                             input logic [23:0] dat, input logic rej);
    @(posedge mclk);
    txWrValid <= 1'b1;
    txWrChan <= ch;
    txWrPhase <= ph;
    txWrData <= dat;
    @(posedge mclk);
    txWrValid <= 1'b0;
    #1;
    cmp("reject", 24'(rej), 24'(txWrReject_q));
  endtask
  // Channel 3 at the given phase must land in slot sl
  task automatic txRound(input logic [15:0] t, input logic [1:0] ph, input logic [5:0] sl);
    logic [23:0] cap;
    writeSample(6'h03, ph, 24'h5a0300 + 24'(sl), 1'b0);
    writeSample(t[5:0], 2'h0, 24'h0000ff, 1'b1);
    runFrame(t, sl, cap);
    cmp("slotData", 24'h5a0300 + 24'(sl), cap);
  endtask
  task automatic rxMap(input logic [5:0] sl, input logic v, input logic [5:0] ch,
                       input logic [1:0] ph);
    @(posedge mclk);
    rxInValid <= 1'b1;
    rxInSlot <= sl;
    rxInData <= 24'h00a5c3;
    @(posedge mclk);
    rxInValid <= 1'b0;
    #1;
    cmp("rxValid", 24'(v), 24'(rxOutValid_q));
    cmp("rxChan", 24'(ch), 24'(rxOutChan_q));
    cmp("rxPhase", 24'(ph), 24'(rxOutPhase_q));
    cmp("rxData", 24'h00a5c3, rxOutData_q);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      runFrame(tab[i], 6'h00, got);
    end
    runFrame(tab[1], 6'h00, got);
    txRound(tab[1], 2'h1, 6'h07);
    rxMap(6'h09, 1'b1, 6'h04, 2'h1);
    runFrame(tab[2], 6'h00, got);
    txRound(tab[2], 2'h3, 6'h0f);
    rxMap(6'h09, 1'b1, 6'h02, 2'h1);
    runFrame(tab[5], 6'h00, got);
    cmp("rateError", 24'h000001, 24'(rateError_q));
    rxMap(6'h09, 1'b0, 6'h02, 2'h1);
    runFrame(tab[5], 6'h00, got);
    cmp("rateError", 24'h000000, 24'(rateError_q));
    giveVerdict();
  end
endmodule
bind smx_channel_mapper smx_mapper_props i_props (.*);
`default_nettype wire
